// ==== hw/gpioei_pins.sv ====
// Reset, NMI, external-interrupt and general-purpose pin logic
`timescale 1ns/10ps

// Operation
// - A rising edge on the NMI pin raises the nonmaskable interrupt.
// - After reset pins 4 to 7 are inputs with their drivers off.
// - With its enable bit (7..4) set, pin 4..7 is an edge interrupt.
// - Bits 3..0 pick the triggering edge of each external interrupt.
// - Pins 9..15 are GPIO or local-bus signals, idle by default.
// - Pin 3 is input-only after reset and may be made bidirectional.
// - Pin 0 is input, output, or the interrupt event output.
// - Pin 8 defaults to serial clock input, or may become GPIO.
module gpioei_pins import gpioei_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins; 4..7 are ext_irq_in_4..ext_irq_in_7
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  input wire logic nmi_pin,
  // Events toward the core
  output logic nmi_event,
  output logic [3:0] ext_irq_event,
  output logic irq,
  // Serial port clock from pin 8
  output logic serial_port_ext_clk_in,
  // Local bus side of pins 9..15
  output logic [6:0] local_bus_pin_in,
  input wire logic [6:0] local_bus_pin_out,
  input wire logic [6:0] local_bus_pin_oe
);

  gpioei_req_t req;
  gpioei_drive_t drive;
  logic [15:0] dir;
  logic [15:0] out_val;
  logic [7:0] irq_enable_bits;
  logic [3:0] ext_irq_edge_select;
  logic [4:0] mode;
  logic [7:0] status;
  logic [7:0] mask;
  logic [16:0] level;
  logic [16:0] level_d;
  logic [16:0] rise;
  logic [16:0] fall;

  gpioei_sync #(
    .WIDTH(17)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({nmi_pin, pin_in}),
    .level(level)
  );

  // Edges of the filtered levels
  assign rise = level & ~level_d;
  assign fall = ~level & level_d;

  // Bus decode
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_dir = req.wr & (req.ofs == GPIOEI_DIR_OFS);
  wire wr_out = req.wr & (req.ofs == GPIOEI_OUT_OFS);
  wire wr_ien = req.wr & (req.ofs == GPIOEI_IEN_OFS);
  wire wr_edge = req.wr & (req.ofs == GPIOEI_EDGE_OFS);
  wire wr_mode = req.wr & (req.ofs == GPIOEI_MODE_OFS);
  wire wr_stat = req.wr & (req.ofs == GPIOEI_STAT_OFS);
  wire wr_mask = req.wr & (req.ofs == GPIOEI_MASK_OFS);
  wire [7:0] rd_ofs = haddr[7:0];
  wire rd_hit = addr_phase & ~hwrite & (haddr[31:8] == 24'h000000);

  // Mode fields
  wire gp0_is_out = mode[1:0] == GPIOEI_GP0_OUT;
  wire gp0_is_evt = mode[1:0] == GPIOEI_GP0_EVENT;
  wire gp8_gpio = mode[GPIOEI_MODE_GP8];
  wire gp3_bidir = mode[GPIOEI_MODE_GP3];
  wire lb_sel = mode[GPIOEI_MODE_LB];

  // Event detection
  wire nmi_hit = rise[16];
  wire [3:0] ext_en = irq_enable_bits[7:4];
  wire [3:0] ext_rise = rise[7:4];
  wire [3:0] ext_fall = fall[7:4];
  // Select 0 picks the rising edge, 1 the falling edge
  wire [3:0] ext_hit = ext_en &
    ((~ext_irq_edge_select & ext_rise) |
     (ext_irq_edge_select & ext_fall));
  wire [7:0] set_bits = {ext_hit, 3'h0, nmi_hit};
  wire [7:0] clr_bits = wr_stat ? hwdata[7:0] : 8'h00;
  // A new event beats a simultaneous write-one-to-clear
  wire [7:0] next_status = (status & ~clr_bits) | set_bits;
  wire next_irq = |(next_status & mask);

  // Read mux
  wire [31:0] rd_data =
    (rd_ofs == GPIOEI_DIR_OFS) ? {16'h0000, dir} :
    (rd_ofs == GPIOEI_OUT_OFS) ? {16'h0000, out_val} :
    (rd_ofs == GPIOEI_IN_OFS) ? {16'h0000, level[15:0]} :
    (rd_ofs == GPIOEI_IEN_OFS) ? {24'h000000, irq_enable_bits} :
    (rd_ofs == GPIOEI_EDGE_OFS) ? {28'h0000000, ext_irq_edge_select} :
    (rd_ofs == GPIOEI_MODE_OFS) ? {27'h0000000, mode} :
    (rd_ofs == GPIOEI_STAT_OFS) ? {24'h000000, status} :
    (rd_ofs == GPIOEI_MASK_OFS) ? {24'h000000, mask} :
    32'h00000000;

  // Pin drive per pin group
  gpioei_drive_t next_drive;
  always_comb
  begin
    next_drive.out = out_val;
    next_drive.oe = dir;
    // Pin 0
    if (gp0_is_evt)
    begin
      next_drive.out[0] = irq;
      next_drive.oe[0] = 1'b1;
    end
    else
    begin
      next_drive.oe[0] = gp0_is_out;
    end
    // Pin 3 stays an input until made bidirectional
    next_drive.oe[3] = gp3_bidir & dir[3];
    // An interrupt pin never drives; dir is zero after reset
    next_drive.oe[7:4] = dir[7:4] & ~ext_en;
    // Pin 8 serves the serial port clock unless made GPIO
    next_drive.oe[8] = gp8_gpio & dir[8];
    // Pins 9..15 belong to the local bus when selected
    if (lb_sel)
    begin
      next_drive.out[15:9] = local_bus_pin_out;
      next_drive.oe[15:9] = local_bus_pin_oe;
    end
  end

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      req.wr <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
      req.rd <= rd_hit;
      req.ofs <= haddr[7:0];
      hrdata <= rd_hit ? rd_data : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dir <= GPIOEI_DIR_RST;
      out_val <= GPIOEI_OUT_RST;
      irq_enable_bits <= GPIOEI_IEN_RST;
      ext_irq_edge_select <= GPIOEI_EDGE_RST;
      mode <= GPIOEI_MODE_RST;
      mask <= GPIOEI_MASK_RST;
    end
    else
    begin
      if (wr_dir)
        dir <= hwdata[15:0];
      if (wr_out)
        out_val <= hwdata[15:0];
      if (wr_ien)
        irq_enable_bits <= {hwdata[7:4], 4'h0};
      if (wr_edge)
        ext_irq_edge_select <= hwdata[3:0];
      if (wr_mode)
        mode <= hwdata[4:0];
      if (wr_mask)
        mask <= hwdata[7:0];
    end
  end

  // Status, events and pin registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      level_d <= '0;
      status <= GPIOEI_STAT_RST;
      irq <= 1'b0;
      nmi_event <= 1'b0;
      ext_irq_event <= 4'h0;
      drive <= '0;
      serial_port_ext_clk_in <= 1'b0;
      local_bus_pin_in <= 7'h00;
    end
    else
    begin
      level_d <= level;
      status <= next_status;
      irq <= next_irq;
      nmi_event <= nmi_hit;
      ext_irq_event <= ext_hit;
      drive <= next_drive;
      serial_port_ext_clk_in <= gp8_gpio ? 1'b0 : level[8];
      local_bus_pin_in <= lb_sel ? level[15:9] : 7'h00;
    end
  end

  assign pin_out = drive.out;
  assign pin_oe = drive.oe;

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_nmi_rise;
    !level[16] ##1 level[16];
  endsequence

  property p_nmi_edge;
    s_nmi_rise |=> nmi_event && status[0];
  endproperty
  a_nmi_edge: assert property (p_nmi_edge)
    else $error("NMI rise did not raise the interrupt");

  property p_nmi_level;
    level[16] && level_d[16] |=> !nmi_event;
  endproperty
  a_nmi_level: assert property (p_nmi_level)
    else $error("NMI fired on a steady level");

  property p_ext_quiet;
    (|ext_en) |=> (pin_oe[7:4] & $past(ext_en)) == 4'h0;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("Interrupt pin driver enabled");

  sequence s_pin4_rise;
    !level[4] ##1 level[4] && ext_en[0];
  endsequence

  property p_ext_polarity;
    s_pin4_rise |=> ext_irq_event[0] == !$past(ext_irq_edge_select[0]);
  endproperty
  a_ext_polarity: assert property (p_ext_polarity)
    else $error("Pin 4 rise handled with wrong polarity");

  property p_ext_disabled;
    ext_en == 4'h0 |=> ext_irq_event == 4'h0;
  endproperty
  a_ext_disabled: assert property (p_ext_disabled)
    else $error("External event while its enable is clear");

  property p_lb_idle;
    !lb_sel |=> pin_oe[15:9] == $past(dir[15:9]) && local_bus_pin_in == 7'h00;
  endproperty
  a_lb_idle: assert property (p_lb_idle)
    else $error("Local-bus pins active while deselected");

  property p_gp3_input;
    !gp3_bidir |=> !pin_oe[3];
  endproperty
  a_gp3_input: assert property (p_gp3_input)
    else $error("Pin 3 driven while input-only");

  property p_gp0_event;
    gp0_is_evt |=> pin_oe[0] && pin_out[0] == $past(irq);
  endproperty
  a_gp0_event: assert property (p_gp0_event)
    else $error("Pin 0 not carrying the interrupt event");

  property p_gp8_clock;
    !gp8_gpio |=> !pin_oe[8] && serial_port_ext_clk_in == $past(level[8]);
  endproperty
  a_gp8_clock: assert property (p_gp8_clock)
    else $error("Pin 8 not serving the serial clock");

  property p_single_pulse;
    nmi_event |=> !nmi_event;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("NMI event longer than one cycle");

  sequence s_pin6_fall;
    level[6] ##1 !level[6] && ext_en[2];
  endsequence

  property p_ext_fall;
    s_pin6_fall |=> ext_irq_event[2] == $past(ext_irq_edge_select[2]);
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("Pin 6 fall handled with wrong polarity");

  property p_ext_one_pulse;
    |ext_irq_event |=> (ext_irq_event & $past(ext_irq_event)) == 4'h0;
  endproperty
  a_ext_one_pulse: assert property (p_ext_one_pulse)
    else $error("External event longer than one cycle");

  property p_nmi_irq;
    status[0] && mask[0] |-> irq;
  endproperty
  a_nmi_irq: assert property (p_nmi_irq)
    else $error("Unmasked NMI status without interrupt");

  property p_nmi_sticky;
    status[0] && !(wr_stat && hwdata[0]) |=> status[0];
  endproperty
  a_nmi_sticky: assert property (p_nmi_sticky)
    else $error("NMI status lost without a clear");

  property p_gp0_input;
    !gp0_is_out && !gp0_is_evt |=> !pin_oe[0];
  endproperty
  a_gp0_input: assert property (p_gp0_input)
    else $error("Pin 0 driven while input-only");

  property p_gp0_output;
    gp0_is_out |=> pin_oe[0] && pin_out[0] == $past(out_val[0]);
  endproperty
  a_gp0_output: assert property (p_gp0_output)
    else $error("Pin 0 not driving its output value");

  property p_lb_active;
    lb_sel |=> pin_oe[15:9] == $past(local_bus_pin_oe) &&
      local_bus_pin_in == $past(level[15:9]);
  endproperty
  a_lb_active: assert property (p_lb_active)
    else $error("Local-bus pins not passed through");

endmodule // gpioei_pins

// ==== hw/gpioei_pkg.sv ====
// Constants and types shared by the pin-function block
package gpioei_pkg;

  localparam int GPIOEI_NPINS = 16;
  localparam int GPIOEI_NEXT = 4;
  localparam int GPIOEI_EXT_LO = 4;
  localparam int GPIOEI_LB_LO = 9;
  localparam int GPIOEI_LB_N = 7;
  localparam int GPIOEI_SYNC_STAGES = 3;

  // Register byte offsets
  localparam logic [7:0] GPIOEI_DIR_OFS = 8'h00;
  localparam logic [7:0] GPIOEI_OUT_OFS = 8'h04;
  localparam logic [7:0] GPIOEI_IN_OFS = 8'h08;
  localparam logic [7:0] GPIOEI_IEN_OFS = 8'h0C;
  localparam logic [7:0] GPIOEI_EDGE_OFS = 8'h10;
  localparam logic [7:0] GPIOEI_MODE_OFS = 8'h14;
  localparam logic [7:0] GPIOEI_STAT_OFS = 8'h18;
  localparam logic [7:0] GPIOEI_MASK_OFS = 8'h1C;

  // Field positions
  localparam int GPIOEI_IEN_LSB = 4;
  localparam int GPIOEI_STAT_NMI = 0;
  localparam int GPIOEI_MODE_GP0_LSB = 0;
  localparam int GPIOEI_MODE_GP8 = 2;
  localparam int GPIOEI_MODE_GP3 = 3;
  localparam int GPIOEI_MODE_LB = 4;

  // Values after reset
  localparam logic [15:0] GPIOEI_DIR_RST = 16'h0000;
  localparam logic [15:0] GPIOEI_OUT_RST = 16'h0000;
  localparam logic [7:0] GPIOEI_IEN_RST = 8'h00;
  localparam logic [3:0] GPIOEI_EDGE_RST = 4'h0;
  localparam logic [4:0] GPIOEI_MODE_RST = 5'h00;
  localparam logic [7:0] GPIOEI_STAT_RST = 8'h00;
  localparam logic [7:0] GPIOEI_MASK_RST = 8'h00;

  // Pin 0 modes
  typedef enum logic [1:0] {
    GPIOEI_GP0_IN = 2'h0,
    GPIOEI_GP0_OUT = 2'h1,
    GPIOEI_GP0_EVENT = 2'h2
  } gpioei_gp0_mode_t;

  // Captured AHB address phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ofs;
  } gpioei_req_t;

  // Registered pin drive
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } gpioei_drive_t;

endpackage

// ==== hw/gpioei_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module gpioei_sync import gpioei_pkg::*;
#(
  parameter int WIDTH = 17
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Asynchronous inputs
  input wire logic [WIDTH-1:0] async_in,
  // Filtered level
  output logic [WIDTH-1:0] level
);

  // Refused while the design is built, not at run time
  if (WIDTH < 1)
  begin : g_bad_width
    $error("gpioei_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // Stage one feeds stage two only; the filter looks at two and three
  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= (agree & stage3) | (~agree & level);
    end
  end

endmodule // gpioei_sync

// ==== sim/gpio_and_ext_interrupt_pins_test.sv ====
// Self-checking bench for the pin-function block
`timescale 1ns/10ps
module gpio_and_ext_interrupt_pins_test import gpioei_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic nmi_pin = 1'b0;
  logic dph_rd = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] ext = 16'h0000;
  logic [6:0] lb_out = 7'h00;
  logic [6:0] lb_oe = 7'h00;
  logic [31:0] hrdata;
  logic hready, hresp, nmi_event, irq, sclk;
  logic [15:0] pin_in, pin_out, pin_oe, r, o, m;
  logic [3:0] ext_irq_event;
  logic [6:0] lb_in;
  logic [31:0] q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_nmi = 0;
  int seed = 4638;
  int n_ext[4] = '{0, 0, 0, 0};

  always #5 hclk = ~hclk;

  gpioei_pins i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .nmi_pin(nmi_pin),
    .nmi_event(nmi_event), .ext_irq_event(ext_irq_event), .irq(irq),
    .serial_port_ext_clk_in(sclk), .local_bus_pin_in(lb_in),
    .local_bus_pin_out(lb_out), .local_bus_pin_oe(lb_oe));

  gpioei_pads i_pads (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext), .pin_in(pin_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Read data is taken at the edge that ends its data phase
  always @(posedge hclk)
  begin
    if (dph_rd && hready === 1'b1)
      check(hrdata, q.pop_front());
    dph_rd <= hsel && htrans[1] && !hwrite && hready;
    if (nmi_event === 1'b1)
      n_nmi++;
    for (int i = 0; i < 4; i++)
      if (ext_irq_event[i] === 1'b1)
        n_ext[i]++;
  end

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      n_mismatch++;
      final_report();
    end
  endtask

  // One single-word transfer; a read notes its expected data
  task automatic bus(input logic wr, input logic [7:0] ofs,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    if (!wr)
      q.push_back(d);
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  initial
  begin
    idle(6);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(pin_oe, 32'h0);
    check(lb_in, 32'h0);
    // Every register resets to zero; 0x20 is unmapped
    for (int a = 0; a <= 32; a += 4)
      bus(1'b0, 8'(a), 32'h0);
    r = 16'($random(seed));
    o = 16'($random(seed));
    ext <= 16'($random(seed));
    m = r & 16'hFEF6;
    bus(1'b1, GPIOEI_DIR_OFS, {16'h0000, r});
    bus(1'b1, GPIOEI_OUT_OFS, {16'h0000, o});
    bus(1'b0, GPIOEI_DIR_OFS, {16'h0000, r});
    bus(1'b0, GPIOEI_OUT_OFS, {16'h0000, o});
    idle(8);
    check(pin_oe, m);
    bus(1'b0, GPIOEI_IN_OFS, {16'h0000, (o & m) | (ext & ~m)});
    bus(1'b1, GPIOEI_MODE_OFS, 32'h0000000C);
    idle(2);
    check(pin_oe, r & 16'hFFFE);
    check(n_ext[0] + n_ext[1] + n_ext[2] + n_ext[3], 0);
    // Pin 0 as a plain output; pins 3 and 8 go back to input-only
    bus(1'b1, GPIOEI_MODE_OFS, 32'h00000001);
    idle(2);
    check(pin_oe, m | 16'h0001);
    check(pin_out, o);
    bus(1'b1, GPIOEI_MODE_OFS, 32'h0);
    bus(1'b1, GPIOEI_DIR_OFS, 32'h0);
    ext <= 16'h0100;
    idle(8);
    check(sclk, 1'b1);
    lb_oe <= 7'($random(seed));
    lb_out <= 7'($random(seed));
    ext <= {7'($random(seed)), 9'h000};
    bus(1'b1, GPIOEI_MODE_OFS, 32'h00000010);
    idle(8);
    check(pin_oe[15:9], lb_oe);
    check(lb_in, (lb_out & lb_oe) | (ext[15:9] & ~lb_oe));
    bus(1'b1, GPIOEI_MODE_OFS, 32'h0);
    ext <= 16'h0000;
    bus(1'b1, GPIOEI_MASK_OFS, 32'h00000001);
    nmi_pin <= 1'b1;
    idle(8);
    check(n_nmi, 1);
    check(irq, 1'b1);
    bus(1'b0, GPIOEI_STAT_OFS, 32'h00000001);
    nmi_pin <= 1'b0;
    idle(8);
    check(n_nmi, 1);
    bus(1'b1, GPIOEI_STAT_OFS, 32'h00000001);
    bus(1'b0, GPIOEI_STAT_OFS, 32'h0);
    idle(2);
    check(irq, 1'b0);
    // Pins 4 and 6 fire on falling edges, 5 and 7 on rising
    bus(1'b1, GPIOEI_EDGE_OFS, 32'h00000005);
    bus(1'b1, GPIOEI_IEN_OFS, 32'h000000F0);
    ext <= 16'h00F0;
    idle(8);
    for (int i = 0; i < 4; i++)
      check(n_ext[i], i % 2);
    ext <= 16'h0000;
    idle(8);
    for (int i = 0; i < 4; i++)
      check(n_ext[i], 1);
    bus(1'b0, GPIOEI_STAT_OFS, 32'h000000F0);
    bus(1'b1, GPIOEI_MASK_OFS, 32'h000000F0);
    bus(1'b1, GPIOEI_MODE_OFS, 32'h00000002);
    idle(3);
    check(pin_oe[0], 1'b1);
    check(pin_out[0], 1'b1);
    bus(1'b1, GPIOEI_STAT_OFS, 32'h000000F0);
    idle(3);
    check(pin_out[0], 1'b0);
    final_report();
  end
endmodule // gpio_and_ext_interrupt_pins_test

// ==== sim/gpioei_pads.sv ====
// External circuits sharing the block's pads
`timescale 1ns/10ps
module gpioei_pads
(
  // From the block
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  // Levels the outside world drives
  input wire logic [15:0] ext_lvl,
  // To the block
  output logic [15:0] pin_in
);
  // Outside drivers yield wherever the block drives, so no contention
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpioei_pads
